// File: src/nvram_host_defs.svh
// timing counts, sequence addresses and pin widths for the nvram host
`ifndef NVRAM_HOST_DEFS_SVH
`define NVRAM_HOST_DEFS_SVH
`define ADDR_W          13
`define DATA_W          8
`define CLK_PERIOD_NS   40
`define SETUP_NS        40
`define ACCESS_NS       80
`define PULSE_NS        80
`define RECOVER_NS      40
`define SETUP_CYC       ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC      ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC       ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC     ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAVE_TIME_US    10000
`define RESTORE_TIME_US 20
`define SAVE_CYC        (`SAVE_TIME_US * 1000 / `CLK_PERIOD_NS)
`define RESTORE_CYC     (`RESTORE_TIME_US * 1000 / `CLK_PERIOD_NS)
`define SEQ_A0          13'h0000
`define SEQ_A1          13'h1555
`define SEQ_A2          13'h0aaa
`define SEQ_A3          13'h1fff
`define SEQ_A4          13'h10f0
`define SEQ_SAVE        13'h0f0f
`define SEQ_RESTORE     13'h0f0e
`endif

// File: src/nvram_host_pkg.sv
// types shared by the nvram host
`include "nvram_host_defs.svh"
package nvram_host_pkg;
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_SAVE    = 3'h2,
    OP_RESTORE = 3'h3
  } op_t;

  typedef struct packed {
    op_t                    op;
    logic [`ADDR_W-1:0]     addr;
    logic [`DATA_W-1:0]     wdata;
  } req_t;

  typedef struct packed {
    logic                   chip_select_n;
    logic                   write_strobe_n;
    logic                   output_drive_n;
    logic [`ADDR_W-1:0]     word_address;
  } pins_t;
endpackage

// File: src/nvram_host.sv
// host sequencer that drives the shadowed sram through its strobes
//
// What this block does
// - address set before write begins and held until strobes rise
// - output drive held high for the whole write cycle
// - save issued as six select-framed reads to fixed addresses
// - first five sequence reads hit 0000, 1555, 0aaa, 1fff, 10f0 in order
// - the sequence uses read cycles only, never writes
// - restore uses the same five reads then a sixth at 0f0e
// - write strobe stays high through all six sequence cycles
`timescale 1ns/100ps
`include "nvram_host_defs.svh"
module nvram_host
  import nvram_host_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // request side
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire req_t              req,
  output logic                   rsp_valid,
  output logic [`DATA_W-1:0]     rsp_rdata,
  // device pins
  output pins_t                  pins,
  input  wire logic [`DATA_W-1:0] data_io_in,
  output logic [`DATA_W-1:0]     data_io_out,
  output logic                   data_io_oe_n
);
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_SETUP  = 6'h02,
    ST_STROBE = 6'h04,
    ST_RECOV  = 6'h08,
    ST_BUSY   = 6'h10,
    ST_DONE   = 6'h20
  } state_t;

  localparam logic [23:0] SETUP_C   = 24'(`SETUP_CYC);
  localparam logic [23:0] ACCESS_C  = 24'(`ACCESS_CYC);
  localparam logic [23:0] PULSE_C   = 24'(`PULSE_CYC);
  localparam logic [23:0] RECOVER_C = 24'(`RECOVER_CYC);
  localparam logic [23:0] SAVE_C    = 24'(`SAVE_CYC);
  localparam logic [23:0] RESTORE_C = 24'(`RESTORE_CYC);

  state_t             state;
  state_t             next_state;
  req_t               cur;
  logic [2:0]         step;
  logic [23:0]        cnt;
  logic [`DATA_W-1:0] rdata;
  logic               done;

  wire is_seq    = (cur.op == OP_SAVE) || (cur.op == OP_RESTORE);
  wire is_write  = (cur.op == OP_WRITE);
  wire cnt_zero  = (cnt == 24'h000000);
  wire last_step = (step == 3'h5);
  wire take      = (state == ST_IDLE) && req_valid;
  wire step_adv  = (state == ST_RECOV) && cnt_zero && is_seq && !last_step;
  // pins load on the edge that loads cur and step, so they must see the values being loaded
  wire req_t       next_cur      = take ? req : cur;
  wire [2:0]       next_step     = take ? 3'h0 : (step_adv ? step + 3'h1 : step);
  wire             next_is_seq   = (next_cur.op == OP_SAVE) || (next_cur.op == OP_RESTORE);
  wire             next_is_write = (next_cur.op == OP_WRITE);
  wire [`ADDR_W-1:0] seq_addr =
      (next_step == 3'h0) ? `SEQ_A0 :
      (next_step == 3'h1) ? `SEQ_A1 :
      (next_step == 3'h2) ? `SEQ_A2 :
      (next_step == 3'h3) ? `SEQ_A3 :
      (next_step == 3'h4) ? `SEQ_A4 :
      // sixth address picks save or restore
      (next_cur.op == OP_SAVE) ? `SEQ_SAVE : `SEQ_RESTORE;
  // full word address for every access
  wire [`ADDR_W-1:0] cyc_addr = next_is_seq ? seq_addr : next_cur.addr;
  wire strobing = (state == ST_STROBE);
  wire [23:0] strobe_len = is_write ? PULSE_C : ACCESS_C;
  // busy time after the sixth read
  wire [23:0] busy_len = (cur.op == OP_SAVE) ? SAVE_C : RESTORE_C;

  assign req_ready = (state == ST_IDLE);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (req_valid) next_state = ST_SETUP;
      ST_SETUP:  if (cnt_zero) next_state = ST_STROBE;
      ST_STROBE: if (cnt_zero) next_state = ST_RECOV;
      // sequence runs back to back, no other access let in
      ST_RECOV:  if (cnt_zero) begin
        next_state = (is_seq && last_step) ? ST_BUSY :
                     (is_seq) ? ST_SETUP : ST_DONE;
      end
      ST_BUSY:   if (cnt_zero) next_state = ST_DONE;
      ST_DONE:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt   <= 24'h000000;
      step  <= 3'h0;
      cur   <= '0;
      rdata <= '0;
    end else begin
      state <= next_state;
      step  <= next_step;
      if (take) begin
        cur  <= req;
        cnt  <= SETUP_C - 24'h000001;
      end else if (!cnt_zero) begin
        cnt <= cnt - 24'h000001;
      end else begin
        unique case (state)
          ST_SETUP:  cnt <= strobe_len - 24'h000001;
          ST_STROBE: cnt <= RECOVER_C - 24'h000001;
          ST_RECOV: begin
            if (is_seq && !last_step) begin
              cnt  <= SETUP_C - 24'h000001;
            end else if (is_seq) begin
              cnt <= busy_len - 24'h000001;
            end
          end
          default: cnt <= 24'h000000;
        endcase
      end
      // sample data at the last strobe cycle, while still driven
      if (strobing && cnt_zero && cur.op == OP_READ) rdata <= data_io_in;
    end
  end

  // strobes come from the state, write only for writes
  // each sequence read is framed by its own select pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      pins         <= '{1'b1, 1'b1, 1'b1, 13'h0000};
      data_io_out  <= '0;
      data_io_oe_n <= 1'b1;
    end else begin
      pins.chip_select_n  <= !(next_state == ST_STROBE);
      // output drive stays high for writes
      // sequence reads keep output drive high
      pins.output_drive_n <= !(next_state == ST_STROBE && cur.op == OP_READ);
      pins.write_strobe_n <= !(next_state == ST_STROBE && is_write);
      // address changes only while select is high
      if (next_state == ST_SETUP) pins.word_address <= cyc_addr;
      // host drives data only across a write
      data_io_oe_n <= !(next_is_write && (next_state == ST_SETUP ||
                        next_state == ST_STROBE || next_state == ST_RECOV));
      if (next_state == ST_SETUP) data_io_out <= next_cur.wdata;
    end
  end

  assign done      = (state == ST_DONE);
  assign rsp_valid = done;
  assign rsp_rdata = rdata;

  // carried out inside the device; host only waits
  sequence s_write_strobe;
    !pins.write_strobe_n;
  endsequence

  a_write_oe_high: assert property (@(posedge clk) disable iff (srst)
    s_write_strobe |-> pins.output_drive_n && !pins.chip_select_n)
    else $error("output drive low during write");
  a_seq_no_write: assert property (@(posedge clk) disable iff (srst)
    (is_seq && state != ST_IDLE) |-> pins.write_strobe_n)
    else $error("write strobe in sequence");
  a_addr_stable: assert property (@(posedge clk) disable iff (srst)
    (!pins.chip_select_n && !$past(pins.chip_select_n)) |-> $stable(pins.word_address))
    else $error("address moved during access");
  a_busy_idle: assert property (@(posedge clk) disable iff (srst)
    (state == ST_BUSY) |-> pins.chip_select_n && data_io_oe_n)
    else $error("pins active while busy");
  a_seq_first: assert property (@(posedge clk) disable iff (srst)
    (is_seq && step == 3'h0 && !pins.chip_select_n) |-> pins.word_address == `SEQ_A0)
    else $error("sequence start address wrong");
  a_save_last: assert property (@(posedge clk) disable iff (srst)
    (cur.op == OP_SAVE && state == ST_BUSY) |-> pins.word_address == `SEQ_SAVE)
    else $error("save sixth address wrong");
  a_restore_last: assert property (@(posedge clk) disable iff (srst)
    (cur.op == OP_RESTORE && state == ST_BUSY) |-> pins.word_address == `SEQ_RESTORE)
    else $error("restore sixth address wrong");
  a_read_strobes: assert property (@(posedge clk) disable iff (srst)
    (!pins.output_drive_n) |-> !pins.chip_select_n && pins.write_strobe_n && data_io_oe_n)
    else $error("read strobes wrong");

  // repeat count tracks the two-cycle access and pulse counts
  sequence s_select_pulse;
    !pins.chip_select_n [*2] ##1 pins.chip_select_n;
  endsequence

  a_select_width: assert property (@(posedge clk) disable iff (srst)
    $fell(pins.chip_select_n) |-> s_select_pulse)
    else $error("select pulse width wrong");
  a_addr_setup: assert property (@(posedge clk) disable iff (srst)
    $fell(pins.chip_select_n) |-> $stable(pins.word_address))
    else $error("address changed with select");
  a_write_data_hold: assert property (@(posedge clk) disable iff (srst)
    $rose(pins.write_strobe_n) |-> !data_io_oe_n && $stable(data_io_out))
    else $error("write data released early");
  a_seq_drive_off: assert property (@(posedge clk) disable iff (srst)
    (is_seq && state != ST_IDLE) |-> pins.output_drive_n)
    else $error("output drive low in sequence");
endmodule

// File: verification/nvram_dev_model.sv
// behavioural shadowed sram seen from its pins
`timescale 1ns/100ps
`include "nvram_host_defs.svh"
module nvram_dev_model
  import nvram_host_pkg::*;
#(parameter int SAVE_NS = 2000, parameter int RESTORE_NS = 400)
(
  // host pins
  input  wire pins_t              pins,
  input  wire logic [`DATA_W-1:0] host_data,
  input  wire logic               host_oe_n,
  // data and status
  output logic [`DATA_W-1:0]      data_io_in,
  output logic                    busy,
  output int                      save_cnt,
  output int                      clash_cnt
);
  logic [`DATA_W-1:0] mem [8192];
  logic [`DATA_W-1:0] nv  [8192];
  logic [`DATA_W-1:0] last;
  logic [2:0]         step;
  logic               drive;
  pins_t              prev;
  logic [`ADDR_W-1:0] seq [5] = '{`SEQ_A0, `SEQ_A1, `SEQ_A2, `SEQ_A3, `SEQ_A4};
  initial begin
    busy = 0;
    step = 0;
    last = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (nv[i]) nv[i] = 8'(i) ^ 8'h5a;
  end
  // drive only in a read, never while busy
  assign drive = !pins.chip_select_n && !pins.output_drive_n && pins.write_strobe_n && !busy;
  always @* if (drive) last = mem[pins.word_address];
  // no pull on the bus, so a released bus shows the inverse
  assign data_io_in = drive ? last : ~last;
  always @(drive, host_oe_n) if (drive && !host_oe_n) clash_cnt++;
  always @(pins) begin
    // write lands as a strobe rises and breaks a sequence
    if (!busy && !prev.chip_select_n && !prev.write_strobe_n
        && (pins.chip_select_n || pins.write_strobe_n)) begin
      mem[prev.word_address] = host_data;
      step = 0;
    end
    // select framed read feeds the detector
    else if (!busy && !prev.chip_select_n && prev.write_strobe_n && pins.chip_select_n)
      track(prev.word_address);
    prev = pins;
  end
  task automatic track(input logic [`ADDR_W-1:0] a);
    // five fixed reads, then the sixth picks the operation
    if (step < 5 && a == seq[step]) step = step + 3'h1;
    else if (step == 5 && (a == `SEQ_SAVE || a == `SEQ_RESTORE)) begin
      step = 0;
      fork nv_op(a == `SEQ_SAVE); join_none
    end
    else step = (a == `SEQ_A0) ? 3'h1 : 3'h0;
  endtask
  // erase then copy, inputs ignored until time is up
  task automatic nv_op(input logic save);
    busy = 1;
    save_cnt += int'(save);
    if (save) foreach (nv[i]) nv[i] = 8'hff;
    if (save) nv = mem;
    if (!save) foreach (mem[i]) mem[i] = 8'h00;
    if (!save) mem = nv;
    #(save ? SAVE_NS : RESTORE_NS);
    busy = 0;
  endtask
endmodule

// File: verification/test_nvram_host.sv
// self-checking bench for the nvram host sequencer
`timescale 1ns/100ps
`include "nvram_host_defs.svh"
module test_nvram_host import nvram_host_pkg::*;;
  logic               clk, srst, req_valid, req_ready, rsp_valid, oe_n, busy;
  req_t               req;
  pins_t              pins;
  logic [`DATA_W-1:0] rdata, din, dout;
  int                 save_cnt, clash_cnt, error_cnt, n_tests, lat, bad;

  nvram_host u_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rdata), .pins(pins), .data_io_in(din),
    .data_io_out(dout), .data_io_oe_n(oe_n));
  nvram_dev_model u_dev (.pins(pins), .host_data(dout), .host_oe_n(oe_n), .data_io_in(din),
    .busy(busy), .save_cnt(save_cnt), .clash_cnt(clash_cnt));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic start(input op_t op, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{op, a, d};
    req_valid = 1;
    @(posedge clk);
    #1;
    req_valid = 0;
  endtask
  // wait on the response pulse, counting cycles from the taking edge
  task automatic op(input op_t o, input logic [12:0] a, input logic [7:0] d);
    start(o, a, d);
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 900);
  endtask
  task automatic t_reset;
    chk({pins.chip_select_n, pins.write_strobe_n, pins.output_drive_n, oe_n}, 4'hf); // idle
    chk(req_ready, 1'b1);
    chk(rsp_valid, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_rw;
    logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    foreach (a[i]) begin
      op(OP_WRITE, a[i], 8'ha5 ^ 8'(i * 17));
      chk(lat, 5); // write latency
    end
    foreach (a[i]) begin
      op(OP_READ, a[i], 8'h00);
      chk(lat, 5); // read latency
      chk(rdata, 8'ha5 ^ 8'(i * 17)); // read data
    end
    chk(clash_cnt, 0); // no bus fight
    $display("read write test done");
  endtask
  task automatic t_restore;
    op(OP_WRITE, 13'h0100, 8'h11);
    op(OP_RESTORE, 13'h0000, 8'h00);
    chk(rsp_valid, 1); // restore ends
    op(OP_READ, 13'h0100, 8'h00);
    chk(rdata, 8'h5a); // reloaded byte
    chk(save_cnt, 0); // no save
    $display("restore test done");
  endtask
  task automatic t_save;
    op(OP_WRITE, 13'h0200, 8'h77);
    start(OP_SAVE, 13'h0000, 8'h00);
    lat = 0;
    bad = 0;
    while (busy !== 1'b1 && lat < 100) begin
      @(negedge clk);
      lat++;
      if (pins.write_strobe_n !== 1'b1) bad++;
    end
    chk(save_cnt, 1); // save started
    chk(u_dev.nv[13'h0200], 8'h77); // saved byte
    repeat (100) begin
      @(negedge clk);
      if (pins.chip_select_n !== 1'b1 || oe_n !== 1'b1) bad++;
    end
    chk(bad, 0); // quiet pins
    $display("save test done");
  endtask
  initial begin
    srst = 1;
    req_valid = 0;
    req = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    #1;
    srst = 0;
    t_reset;
    t_rw;
    t_restore;
    t_save;
    tally_and_finish;
  end
  // watchdog well beyond the roughly 720 cycles the tests need
  initial begin
    #(3000 * 40);
    error_cnt++;
    tally_and_finish;
  end
endmodule
